// ==== rtl/pmc_core.sv ====
// power mode controller: mode sequencing, gating, wake and reset cause
// assumes inputs synchronous to mclk; wake pins already debounced
//
// What this block does
// - active: cpu runs, enabled peripherals clocked
// - idle: gate cpu and memory, interrupt wakes
// - wake delays 14, 151, 1015 us
// - standby: only always-on, rtc or pin wakes
// - standby wake resumes cpu, retention kept
// - standby holds io pins latched
// - shutdown powers all off, io latched
// - shutdown pin level change wakes as reset
// - reset cause readable: wake, pin, por
// - shutdown keeps only io latch and por monitor
// - wake sources allowed per mode
// - brownout continuous, duty cycled, off; por on except while reset pin held
// - fast clock is doubled crystal reference
// - internal fast osc selectable for cpu
// - slow internal osc when no crystal
// - slow clock routable to a pin
// - rtc wakes from any powered state
// - each io wakes on chosen edge
module pmc_core (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire pmc_pkg::pmc_req_t sw_req,
    input wire logic irq_event,
    input wire logic rtc_event,
    input wire logic reset_pin_n,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_in,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_out_cpu,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_wake_en,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_wake_rise,
    input wire logic [pmc_pkg::NUM_IO-1:0] io_shdn_wake_en,
    input wire pmc_pkg::pmc_clkcfg_t clk_cfg,
    input wire logic fast_crystal_osc,
    input wire logic fast_internal_osc,
    input wire logic slow_crystal_osc,
    input wire logic slow_internal_osc,
    output pmc_pkg::pmc_mode_t mode,
    output pmc_pkg::pmc_gate_t gates,
    output logic [pmc_pkg::NUM_IO-1:0] io_out,
    output logic [1:0] reset_cause,
    output logic cpu_resume,
    output logic sys_reset,
    output logic brownout_monitor_en,
    output logic por_monitor_en,
    output logic fast_crystal_doubler_en,
    output logic fast_clk,
    output logic slow_clk,
    output logic slow_internal_osc_en,
    output logic lf_pin_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pmc_pkg::pmc_mode_t mode_q, mode_d;
    pmc_pkg::pmc_mode_t from_q, from_d;
    logic [pmc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [pmc_pkg::NUM_IO-1:0] io_prev_q, io_prev_d;
    logic [pmc_pkg::NUM_IO-1:0] io_lat_q, io_lat_d;
    logic [1:0] cause_q, cause_d;
    logic [7:0] bod_q, bod_d;
    logic resume_q, resume_d;
    logic pin_edge, pin_change, pin_wake, rtc_wake, shdn_wake;
    logic [pmc_pkg::CNT_W-1:0] wake_len;
    logic [pmc_pkg::CNT_W-1:0] wake_age_q, wake_age_d;

    localparam logic [pmc_pkg::CNT_W-1:0] IDLE_N =
        pmc_pkg::CNT_W'(pmc_pkg::IDLE_WAKE_CYC);
    localparam logic [pmc_pkg::CNT_W-1:0] STBY_N =
        pmc_pkg::CNT_W'(pmc_pkg::STBY_WAKE_CYC);
    localparam logic [pmc_pkg::CNT_W-1:0] SHDN_N =
        pmc_pkg::CNT_W'(pmc_pkg::SHDN_WAKE_CYC);
    localparam logic [pmc_pkg::CNT_W-1:0] HF_N =
        pmc_pkg::CNT_W'(pmc_pkg::HF_START_CYC);

    // ------------------------------------------------------------
    // wake detection
    // ------------------------------------------------------------
    // edge wake honours the configured polarity per pin
    assign pin_edge = |(io_wake_en & ((io_wake_rise & io_in & ~io_prev_q)
        | (~io_wake_rise & ~io_in & io_prev_q)));
    // shutdown wake is any level change, either direction
    assign pin_change = |(io_shdn_wake_en & (io_in ^ io_prev_q));
    assign pin_wake = pin_edge &&
        (mode_q inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_IDLE,
                        pmc_pkg::PMC_STBY});
    assign shdn_wake = pin_change && mode_q == pmc_pkg::PMC_SHDN;
    assign rtc_wake = rtc_event && (mode_q inside {pmc_pkg::PMC_ACTIVE,
        pmc_pkg::PMC_IDLE, pmc_pkg::PMC_STBY});

    always_comb
    begin
        case (from_q)
            pmc_pkg::PMC_IDLE: wake_len = IDLE_N;
            pmc_pkg::PMC_STBY: wake_len = STBY_N;
            default: wake_len = SHDN_N;
        endcase
    end

    // ------------------------------------------------------------
    // mode sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        mode_d = mode_q;
        from_d = from_q;
        cnt_d = cnt_q;
        cause_d = cause_q;
        resume_d = 1'b0;
        io_prev_d = io_in;
        io_lat_d = io_lat_q;
        if (!reset_pin_n)
        begin
            // reset pin overrides every mode
            mode_d = pmc_pkg::PMC_HELD;
            from_d = pmc_pkg::PMC_HELD;
            cause_d = pmc_pkg::CAUSE_PIN;
            cnt_d = '0;
        end
        else
        begin
            case (mode_q)
                pmc_pkg::PMC_ACTIVE:
                begin
                    // latch pin state continuously until entry
                    io_lat_d = io_out_cpu;
                    if (sw_req == pmc_pkg::REQ_IDLE)
                    begin
                        mode_d = pmc_pkg::PMC_IDLE;
                    end
                    else if (sw_req == pmc_pkg::REQ_STBY ||
                             sw_req == pmc_pkg::REQ_SHDN)
                    begin
                        // cpu halts first, fast clock goes after
                        mode_d = pmc_pkg::PMC_ENTER;
                        from_d = (sw_req == pmc_pkg::REQ_STBY) ?
                            pmc_pkg::PMC_STBY : pmc_pkg::PMC_SHDN;
                    end
                end
                pmc_pkg::PMC_ENTER:
                begin
                    mode_d = from_q;
                end
                pmc_pkg::PMC_IDLE:
                begin
                    if (irq_event || rtc_wake || pin_wake)
                    begin
                        mode_d = pmc_pkg::PMC_WAKE;
                        from_d = pmc_pkg::PMC_IDLE;
                        cnt_d = '0;
                    end
                end
                pmc_pkg::PMC_STBY:
                begin
                    if (rtc_wake || pin_wake)
                    begin
                        mode_d = pmc_pkg::PMC_WAKE;
                        from_d = pmc_pkg::PMC_STBY;
                        cnt_d = '0;
                    end
                end
                pmc_pkg::PMC_SHDN:
                begin
                    if (shdn_wake)
                    begin
                        mode_d = pmc_pkg::PMC_WAKE;
                        from_d = pmc_pkg::PMC_SHDN;
                        cause_d = pmc_pkg::CAUSE_WAKE;
                        cnt_d = '0;
                    end
                end
                pmc_pkg::PMC_HELD:
                begin
                    mode_d = pmc_pkg::PMC_WAKE;
                    cnt_d = '0;
                end
                pmc_pkg::PMC_WAKE:
                begin
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == wake_len - 1'b1)
                    begin
                        mode_d = pmc_pkg::PMC_ACTIVE;
                        // only standby returns to saved context
                        resume_d = (from_q == pmc_pkg::PMC_STBY);
                    end
                end
                default:
                begin
                    mode_d = pmc_pkg::PMC_ACTIVE;
                end
            endcase
        end
    end

    // brownout sample strobe in standby; wake age only feeds the checks
    always_comb
    begin
        bod_d = (mode_q == pmc_pkg::PMC_STBY) ? bod_q + 8'h01 : 8'h00;
        wake_age_d = (mode_q == pmc_pkg::PMC_WAKE) ? wake_age_q + 1'b1 : '0;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_q <= pmc_pkg::PMC_WAKE;
            from_q <= pmc_pkg::PMC_HELD;
            cnt_q <= '0;
            cause_q <= pmc_pkg::CAUSE_POR;
            resume_q <= 1'b0;
            io_prev_q <= '0;
            io_lat_q <= '0;
            bod_q <= 8'h00;
            wake_age_q <= '0;
        end
        else if (clk_en)
        begin
            mode_q <= mode_d;
            from_q <= from_d;
            cnt_q <= cnt_d;
            cause_q <= cause_d;
            resume_q <= resume_d;
            io_prev_q <= io_prev_d;
            io_lat_q <= io_lat_d;
            bod_q <= bod_d;
            wake_age_q <= wake_age_d;
        end
    end

    // ------------------------------------------------------------
    // gating and outputs
    // ------------------------------------------------------------
    logic in_wake_hf;
    assign in_wake_hf = mode_q == pmc_pkg::PMC_WAKE && cnt_q >= HF_N;

    always_comb
    begin
        gates = '0;
        case (mode_q)
            pmc_pkg::PMC_ACTIVE:
            begin
                gates = '1;
                gates.io_latch = 1'b0;
            end
            pmc_pkg::PMC_IDLE:
            begin
                gates = '1;
                gates.cpu_clk_en = 1'b0;
                gates.mem_clk_en = 1'b0;
                gates.io_latch = 1'b0;
            end
            pmc_pkg::PMC_ENTER:
            begin
                // cpu stopped while fast clock still runs
                gates.hf_clk_en = 1'b1;
                gates.aon_pwr_en = 1'b1;
                gates.main_pwr_en = 1'b1;
                gates.io_latch = 1'b1;
            end
            pmc_pkg::PMC_STBY:
            begin
                gates.aon_pwr_en = 1'b1;
                gates.io_latch = 1'b1;
            end
            pmc_pkg::PMC_SHDN:
            begin
                gates.io_latch = 1'b1;
            end
            pmc_pkg::PMC_WAKE:
            begin
                gates.aon_pwr_en = 1'b1;
                gates.main_pwr_en = 1'b1;
                gates.hf_clk_en = in_wake_hf;
                gates.io_latch = from_q == pmc_pkg::PMC_STBY ||
                    from_q == pmc_pkg::PMC_SHDN;
            end
            default:
            begin
                gates = '0;
            end
        endcase
    end

    assign mode = mode_q;
    assign io_out = gates.io_latch ? io_lat_q : io_out_cpu;
    assign reset_cause = cause_q;
    assign cpu_resume = resume_q;
    // shutdown and held wakes restart from reset; registers lost
    assign sys_reset = mode_q == pmc_pkg::PMC_HELD ||
        mode_q == pmc_pkg::PMC_SHDN ||
        (mode_q == pmc_pkg::PMC_WAKE &&
         from_q inside {pmc_pkg::PMC_SHDN, pmc_pkg::PMC_HELD});
    assign brownout_monitor_en = mode_q inside {pmc_pkg::PMC_ACTIVE,
        pmc_pkg::PMC_IDLE, pmc_pkg::PMC_ENTER, pmc_pkg::PMC_WAKE} ||
        (mode_q == pmc_pkg::PMC_STBY && bod_q == 8'h00);
    assign por_monitor_en = mode_q != pmc_pkg::PMC_HELD;
    assign fast_crystal_doubler_en = gates.hf_clk_en;
    // clock muxes are behavioural; a glitch-free cell replaces them
    assign fast_clk = gates.hf_clk_en & (clk_cfg.hf_sel_internal ?
        fast_internal_osc : fast_crystal_osc);
    assign slow_internal_osc_en = !clk_cfg.lf_crystal_fitted &&
        gates.aon_pwr_en;
    assign slow_clk = gates.aon_pwr_en & (clk_cfg.lf_crystal_fitted ?
        slow_crystal_osc : slow_internal_osc);
    assign lf_pin_out = clk_cfg.lf_to_pin & slow_clk;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n || !clk_en);

    held_on_pin_a: assert property (!reset_pin_n |=>
        mode_q == pmc_pkg::PMC_HELD)
        else $error("reset pin did not hold");
    idle_gate_a: assert property (mode_q == pmc_pkg::PMC_IDLE |->
        !gates.cpu_clk_en && !gates.mem_clk_en && gates.periph_clk_en)
        else $error("idle gating wrong");
    idle_wake_a: assert property (mode_q == pmc_pkg::PMC_IDLE &&
        irq_event && reset_pin_n |=> mode_q == pmc_pkg::PMC_WAKE)
        else $error("interrupt did not wake idle");
    stby_irq_a: assert property (mode_q == pmc_pkg::PMC_STBY &&
        !rtc_event && !pin_edge && reset_pin_n |=>
        mode_q == pmc_pkg::PMC_STBY)
        else $error("standby left without wake source");
    stby_latch_a: assert property (mode_q == pmc_pkg::PMC_STBY |->
        io_out == io_lat_q && gates.aon_pwr_en && !gates.main_pwr_en)
        else $error("standby io not latched");
    shdn_off_a: assert property (mode_q == pmc_pkg::PMC_SHDN |->
        !gates.aon_pwr_en && gates.io_latch && !brownout_monitor_en)
        else $error("shutdown not fully off");
    shdn_cause_a: assert property (shdn_wake && reset_pin_n |=>
        reset_cause == pmc_pkg::CAUSE_WAKE)
        else $error("wake cause not recorded");
    rtc_shdn_a: assert property (mode_q == pmc_pkg::PMC_SHDN &&
        !pin_change && reset_pin_n |=> mode_q == pmc_pkg::PMC_SHDN)
        else $error("shutdown left without pin change");
    enter_seq_a: assert property (mode_q == pmc_pkg::PMC_ENTER |->
        !gates.cpu_clk_en && gates.hf_clk_en)
        else $error("cpu not stopped before clock off");
    idle_time_a: assert property (mode_q == pmc_pkg::PMC_WAKE &&
        from_q == pmc_pkg::PMC_IDLE && wake_age_q == IDLE_N - 1'b1 &&
        reset_pin_n |=> mode_q == pmc_pkg::PMC_ACTIVE)
        else $error("idle wake time wrong");
    idle_early_a: assert property (mode_q == pmc_pkg::PMC_WAKE &&
        from_q == pmc_pkg::PMC_IDLE && wake_age_q < IDLE_N - 1'b1 &&
        reset_pin_n |=> mode_q == pmc_pkg::PMC_WAKE)
        else $error("idle wake ended early");

    cov_idle_c: cover property (mode_q == pmc_pkg::PMC_IDLE ##1
        mode_q == pmc_pkg::PMC_WAKE);
    cov_stby_c: cover property (mode_q == pmc_pkg::PMC_STBY ##1
        mode_q == pmc_pkg::PMC_WAKE);
    cov_shdn_c: cover property (shdn_wake);
    cov_held_c: cover property (mode_q == pmc_pkg::PMC_HELD);

endmodule

// ==== pkg/pmc_pkg.sv ====
// package for the power mode controller: modes, timing, carriers
// assumes a single 200 MHz clock domain; no bus, plain ports
package pmc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int IDLE_WAKE_US = 14;
    localparam int STBY_WAKE_US = 151;
    localparam int SHDN_WAKE_US = 1015;
    localparam int IDLE_WAKE_CYC = IDLE_WAKE_US * CLK_MHZ;
    localparam int STBY_WAKE_CYC = STBY_WAKE_US * CLK_MHZ;
    localparam int SHDN_WAKE_CYC = SHDN_WAKE_US * CLK_MHZ;
    // share of the standby wake spent restarting the fast clock
    localparam int HF_START_CYC = 8;
    // brownout sampling period while in standby
    localparam int BOD_DUTY_CYC = 256;
    localparam int CNT_W = 18;
    localparam int NUM_IO = 8;

    // ------------------------------------------------------------
    // reset cause encoding
    // ------------------------------------------------------------
    localparam logic [1:0] CAUSE_POR = 2'h0;
    localparam logic [1:0] CAUSE_PIN = 2'h1;
    localparam logic [1:0] CAUSE_WAKE = 2'h2;

    // ------------------------------------------------------------
    // modes and requests
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PMC_ACTIVE = 3'h0,
        PMC_IDLE = 3'h1,
        PMC_STBY = 3'h2,
        PMC_SHDN = 3'h3,
        PMC_HELD = 3'h4,
        PMC_WAKE = 3'h5,
        PMC_ENTER = 3'h6
    } pmc_mode_t;

    typedef enum logic [1:0] {
        REQ_NONE = 2'h0,
        REQ_IDLE = 2'h1,
        REQ_STBY = 2'h2,
        REQ_SHDN = 2'h3
    } pmc_req_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic mem_clk_en;
        logic periph_clk_en;
        logic hf_clk_en;
        logic aon_pwr_en;
        logic main_pwr_en;
        logic io_latch;
    } pmc_gate_t;

    typedef struct packed {
        logic hf_sel_internal;
        logic lf_crystal_fitted;
        logic lf_to_pin;
    } pmc_clkcfg_t;

endpackage

// ==== test/pmc_pins_model.sv ====
// model of the wake pins and the reset pin outside the block
// assumes mclk from the bench; drives 1 ns after rising edges
module pmc_pins_model (
    input wire logic mclk,
    output logic [pmc_pkg::NUM_IO-1:0] io_in,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // push-pull pins on the board: a level holds until changed
    initial
    begin
        io_in = 8'h00;
        reset_pin_n = 1'h1;
    end
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge mclk);
        #1;
        io_in[idx] = lvl;
    endtask
    task automatic hold_reset(input int cycles);
        @(posedge mclk);
        #1;
        reset_pin_n = 1'h0;
        repeat (cycles) @(posedge mclk);
        #1;
        reset_pin_n = 1'h1;
    endtask
endmodule

// ==== test/tb_pmc_core.sv ====
// self-checking bench for pmc_core: modes, wakes, gating, clocks
// assumes pmc_pins_model on the pins; wake counts are fixed in the
// package, so the run is long (two full shutdown-length wakes)
module tb_pmc_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, clk_en, irq_event, rtc_event, reset_pin_n;
    pmc_pkg::pmc_req_t sw_req;
    logic [pmc_pkg::NUM_IO-1:0] io_in, io_out_cpu, io_wake_en;
    logic [pmc_pkg::NUM_IO-1:0] io_wake_rise, io_shdn_wake_en, io_out;
    pmc_pkg::pmc_clkcfg_t clk_cfg;
    logic [3:0] osc;
    pmc_pkg::pmc_mode_t mode, last_mode;
    pmc_pkg::pmc_gate_t gates;
    logic [1:0] reset_cause;
    logic cpu_resume, sys_reset, bod_en, por_en, dbl_en;
    logic fast_clk, slow_clk, slow_osc_en, lf_pin_out;
    pmc_pkg::pmc_mode_t exp_q[$];
    int num_errors = 0;
    int comparisons = 0;
    int seed = 32'h2b8e6ddd;
    int ticks = 0;
    int n;

    pmc_core u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .sw_req(sw_req), .irq_event(irq_event), .rtc_event(rtc_event),
        .reset_pin_n(reset_pin_n), .io_in(io_in), .io_out_cpu(io_out_cpu),
        .io_wake_en(io_wake_en), .io_wake_rise(io_wake_rise),
        .io_shdn_wake_en(io_shdn_wake_en), .clk_cfg(clk_cfg),
        .fast_crystal_osc(osc[0]), .fast_internal_osc(osc[1]),
        .slow_crystal_osc(osc[2]), .slow_internal_osc(osc[3]),
        .mode(mode), .gates(gates), .io_out(io_out),
        .reset_cause(reset_cause), .cpu_resume(cpu_resume),
        .sys_reset(sys_reset), .brownout_monitor_en(bod_en),
        .por_monitor_en(por_en), .fast_crystal_doubler_en(dbl_en),
        .fast_clk(fast_clk), .slow_clk(slow_clk),
        .slow_internal_osc_en(slow_osc_en), .lf_pin_out(lf_pin_out));
    pmc_pins_model u_pins (.mclk(mclk), .io_in(io_in),
        .reset_pin_n(reset_pin_n));

    // ------------------------------------------------------------
    // clock, timeout, mode monitor, helpers
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        ticks <= ticks + 1;
        if (ticks == 600000)
        begin
            num_errors++;
            results();
        end
    end
    // every mode change must match the oldest noted expectation
    always @(posedge mclk)
    begin
        #2;
        if (rst_n === 1'h1 && mode !== last_mode)
        begin
            last_mode = mode;
            if (exp_q.size() == 0)
                chk("mode unexpected", 32'hFF, mode);
            else
                chk("mode", exp_q.pop_front(), mode);
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic note(input pmc_pkg::pmc_mode_t a, b, c);
        exp_q.push_back(a);
        exp_q.push_back(b);
        exp_q.push_back(c);
    endtask
    task automatic req(input pmc_pkg::pmc_req_t r);
        sw_req = r;
        cyc(1);
        sw_req = pmc_pkg::REQ_NONE;
    endtask
    task automatic wait_wake();
        for (int i = 0; i < 40 && mode !== pmc_pkg::PMC_WAKE; i++)
            cyc(1);
    endtask
    // one cycle of slack either way for where the count starts
    task automatic wake_time(input int x, input int c0, input string what);
        int c;
        c = c0;
        while (mode !== pmc_pkg::PMC_ACTIVE && c < 210000)
        begin
            cyc(1);
            c++;
        end
        if (c >= x - 1 && c <= x + 1)
            c = x;
        chk(what, x, c);
    endtask
    task automatic results();
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'h0;
        clk_en = 1'h1;
        sw_req = pmc_pkg::REQ_NONE;
        irq_event = 1'h0;
        rtc_event = 1'h0;
        io_out_cpu = 8'h00;
        io_wake_en = 8'h00;
        io_wake_rise = 8'h00;
        io_shdn_wake_en = 8'h00;
        clk_cfg = 3'h0;
        osc = 4'h0;
        last_mode = pmc_pkg::PMC_WAKE;
        exp_q.push_back(pmc_pkg::PMC_ACTIVE);
        cyc(10);
        chk("por cause", pmc_pkg::CAUSE_POR, reset_cause);
        rst_n = 1'h1;
        wake_time(pmc_pkg::SHDN_WAKE_CYC, 0, "por wake");
        chk("active gates", 4'hF, gates[6:3]);
        chk("active bod", 1, bod_en & por_en);
        for (int i = 0; i < 32; i++)
        begin
            clk_cfg = 3'(i);
            io_out_cpu = 8'($random(seed));
            osc = 4'($random(seed));
            #1;
            chk("io passthru", io_out_cpu, io_out);
            chk("doubler", 1, dbl_en);
            chk("fast_clk", clk_cfg.hf_sel_internal ? osc[1] : osc[0],
                fast_clk);
            chk("slow_clk", clk_cfg.lf_crystal_fitted ? osc[2] : osc[3],
                slow_clk);
            chk("slow osc en", !clk_cfg.lf_crystal_fitted, slow_osc_en);
            chk("lf pin", clk_cfg.lf_to_pin & slow_clk, lf_pin_out);
            cyc(1);
        end
        note(pmc_pkg::PMC_IDLE, pmc_pkg::PMC_WAKE, pmc_pkg::PMC_ACTIVE);
        req(pmc_pkg::REQ_IDLE);
        chk("idle gates", 4'h3, gates[6:3]);
        cyc(20);
        chk("idle bod", 1, bod_en);
        // a frozen block must ignore the pending interrupt
        clk_en = 1'h0;
        irq_event = 1'h1;
        cyc(3);
        chk("frozen idle", pmc_pkg::PMC_IDLE, mode);
        clk_en = 1'h1;
        irq_event = 1'h1;
        cyc(1);
        irq_event = 1'h0;
        wait_wake();
        wake_time(pmc_pkg::IDLE_WAKE_CYC, 0, "idle wake");
        // standby, woken by the rtc; irq and requests must not wake it
        note(pmc_pkg::PMC_ENTER, pmc_pkg::PMC_STBY, pmc_pkg::PMC_WAKE);
        exp_q.push_back(pmc_pkg::PMC_ACTIVE);
        io_out_cpu = 8'hA5;
        req(pmc_pkg::REQ_STBY);
        chk("enter gates", 4'h1, gates[6:3]);
        cyc(1);
        chk("stby hf", 0, gates.hf_clk_en);
        chk("stby aon", 1, gates.aon_pwr_en);
        io_out_cpu = 8'h5A;
        irq_event = 1'h1;
        sw_req = pmc_pkg::REQ_IDLE;
        cyc(1);
        irq_event = 1'h0;
        sw_req = pmc_pkg::REQ_NONE;
        n = 0;
        for (int i = 0; i < 512; i++)
        begin
            cyc(1);
            n += bod_en;
        end
        chk("stby bod duty", 2, n);
        chk("stby io", 8'hA5, io_out);
        chk("stby hold", pmc_pkg::PMC_STBY, mode);
        rtc_event = 1'h1;
        cyc(1);
        rtc_event = 1'h0;
        wait_wake();
        chk("wake hf", 4'h0, gates[6:3]);
        cyc(pmc_pkg::HF_START_CYC + 2);
        chk("wake hf up", 4'h1, gates[6:3]);
        wake_time(pmc_pkg::STBY_WAKE_CYC, pmc_pkg::HF_START_CYC + 2,
            "stby wake");
        chk("resume", 1, cpu_resume);
        cyc(1);
        chk("resume pulse", 0, cpu_resume);
        // standby, woken by a falling edge only
        note(pmc_pkg::PMC_ENTER, pmc_pkg::PMC_STBY, pmc_pkg::PMC_WAKE);
        exp_q.push_back(pmc_pkg::PMC_ACTIVE);
        io_wake_en = 8'h08;
        req(pmc_pkg::REQ_STBY);
        u_pins.set_pin(3, 1'h1);
        cyc(5);
        chk("rise ignored", pmc_pkg::PMC_STBY, mode);
        u_pins.set_pin(3, 1'h0);
        wait_wake();
        wake_time(pmc_pkg::STBY_WAKE_CYC, 0, "edge wake");
        // reset pin held: pin edges must not wake
        note(pmc_pkg::PMC_HELD, pmc_pkg::PMC_WAKE, pmc_pkg::PMC_ACTIVE);
        io_wake_rise = 8'hFF;
        fork
            u_pins.hold_reset(30);
        join_none
        cyc(5);
        chk("held sysrst", 1, sys_reset);
        chk("held monitors", 0, por_en | bod_en);
        u_pins.set_pin(3, 1'h1);
        cyc(3);
        chk("held edge", pmc_pkg::PMC_HELD, mode);
        wait_wake();
        chk("pin cause", pmc_pkg::CAUSE_PIN, reset_cause);
        wake_time(pmc_pkg::SHDN_WAKE_CYC, 0, "held wake");
        // shutdown: only a level change on a shutdown pin wakes
        note(pmc_pkg::PMC_ENTER, pmc_pkg::PMC_SHDN, pmc_pkg::PMC_WAKE);
        io_wake_rise = 8'h00;
        io_shdn_wake_en = 8'h40;
        io_out_cpu = 8'h3C;
        req(pmc_pkg::REQ_SHDN);
        cyc(1);
        chk("shdn pwr", 0, gates.aon_pwr_en | gates.main_pwr_en);
        chk("shdn sysrst", 1, sys_reset & por_en);
        chk("shdn bod", 0, bod_en);
        io_out_cpu = 8'hC3;
        rtc_event = 1'h1;
        cyc(1);
        rtc_event = 1'h0;
        u_pins.set_pin(3, 1'h0);
        cyc(3);
        chk("shdn io", 8'h3C, io_out);
        chk("shdn hold", pmc_pkg::PMC_SHDN, mode);
        u_pins.set_pin(6, 1'h1);
        wait_wake();
        chk("wake cause", pmc_pkg::CAUSE_WAKE, reset_cause);
        chk("wake sysrst", 1, sys_reset);
        cyc(2);
        results();
    end
endmodule
